// [rtl/burst_flash_read_port.sv]
module burst_flash_read_port
    import flash_read_pkg::*;
#(
    parameter int MEM_WORDS = 256
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire bus_in_s busIn,
    input wire logic syncMode,
    input wire logic [WAIT_W-1:0] wait_state_count,
    input wire logic ready_timing_select,
    input wire logic [DATA_W-1:0] memData,
    output logic [ADDR_W-1:0] memAddr,
    output bus_out_s busOut
);
    ////////////////////////////////////////////////////////////////////////////
    // pins are driven by the host, so they pass the three-stage synchroniser;
    // the bus clock is the same clock here, sync mode samples each rising edge
    localparam int SYNC_W = 3 + ADDR_W;
    logic [SYNC_W-1:0] syncVal;
    logic [SYNC_W-1:0] syncRaw;
    pin_sync #(.WIDTH(SYNC_W)) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .pinIn({busIn.chipSelectN, busIn.outputEnableN, busIn.addressValidStrobeN,
            busIn.address}),
        .stable(syncVal),
        .agreed(syncRaw)
    );
    logic csN, oeN, strobeN;
    logic [ADDR_W-1:0] addrPin;
    assign csN = syncVal[SYNC_W-1];
    assign oeN = syncVal[SYNC_W-2];
    assign strobeN = syncVal[SYNC_W-3];
    assign addrPin = syncRaw[ADDR_W-1:0];

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        mode_e mode;
        logic [CNT_W-1:0] count;
        logic [ADDR_W-1:0] addr;
        logic strobePrev;
        logic csPrev;
        logic [DATA_W-1:0] dataOut;
        logic dataOe;
        logic ready;
        logic readyOe;
    } state_s;
    state_s st_q, st_d;

    logic strobeRise, strobeLow, csFall;
    assign strobeRise = strobeN && !st_q.strobePrev;
    assign strobeLow = !strobeN;
    assign csFall = !csN && st_q.csPrev;

    always_comb begin
        st_d = st_q;
        st_d.strobePrev = strobeN;
        st_d.csPrev = csN;
        st_d.ready = 1'b0;
        if (csN) begin
            st_d.mode = IDLE;
        end else if (syncMode) begin
            if (strobeLow) begin
                st_d.addr = addrPin;
                st_d.mode = SYNC_WAIT;
                st_d.count = CNT_W'(wait_state_count) - CNT_W'(1);
            end else unique case (st_q.mode)
                SYNC_WAIT: begin
                    if (st_q.count <= CNT_W'(1)) begin
                        st_d.mode = SYNC_BURST;
                        st_d.dataOut = memData;
                        st_d.addr = st_q.addr + ADDR_W'(1);
                        // ready stays up through the first word in both timings
                        st_d.ready = 1'b1;
                    end else begin
                        st_d.count = st_q.count - CNT_W'(1);
                        st_d.ready = ready_timing_select && st_q.count == CNT_W'(2);
                        // array answers one edge after the pointer moves
                        if (st_q.count == CNT_W'(2)) begin
                            st_d.addr = st_q.addr + ADDR_W'(1);
                        end
                    end
                end
                SYNC_BURST: begin
                    st_d.dataOut = memData;
                    st_d.addr = st_q.addr + ADDR_W'(1);
                    st_d.ready = 1'b1;
                end
                default: begin
                end
            endcase
        end else begin
            // latch on strobe rise, on select fall behind a raised
            // strobe, and follow the address while a strobe tied low stays open
            if (strobeRise || (csFall && strobeN && st_q.strobePrev)
                || (strobeLow && (csFall || st_q.strobePrev || addrPin != st_q.addr))) begin
                st_d.addr = addrPin;
                st_d.mode = ASYNC_ACC;
                st_d.count = CNT_W'(ASYNC_ACCESS_CYC);
            end else if (st_q.mode == ASYNC_ACC || st_q.mode == IDLE) begin
                if (st_q.mode == IDLE && strobeN
                    && addrPin[ADDR_W-1:PAGE_W] == st_q.addr[ADDR_W-1:PAGE_W]
                    && addrPin[PAGE_W-1:0] != st_q.addr[PAGE_W-1:0]) begin
                    st_d.addr = addrPin;
                    st_d.mode = ASYNC_ACC;
                    // one extra edge for the array lookup behind memAddr
                    st_d.count = CNT_W'(PAGE_ACCESS_CYC) + CNT_W'(1);
                end else if (st_q.mode == ASYNC_ACC) begin
                    if (st_q.count <= CNT_W'(1)) begin
                        st_d.mode = IDLE;
                        st_d.dataOut = memData;
                        st_d.ready = 1'b1;
                    end else begin
                        st_d.count = st_q.count - CNT_W'(1);
                    end
                end
            end
        end
        st_d.readyOe = !csN;
        st_d.dataOe = !oeN;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_q <= '{mode: IDLE, count: '0, addr: '0, strobePrev: 1'b1, csPrev: 1'b1,
                dataOut: '0, dataOe: 1'b0, ready: 1'b0, readyOe: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    // memory lookup address follows the current pointer
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            memAddr <= '0;
        end else begin
            memAddr <= st_d.addr;
        end
    end

    always_comb begin
        busOut.dataOut = st_q.dataOut;
        busOut.dataOe = st_q.dataOe;
        busOut.ready = st_q.ready;
        busOut.readyOe = st_q.readyOe;
    end
endmodule // burst_flash_read_port

// [rtl/flash_read_pkg.sv]
// Function
// - synchronous address captured on rising clock
// - first word after wait states minus one
// - chip select floats ready, enable floats data
// - asynchronous address captured on strobe rise
// - strobe before or after chip select works
// - strobe tied to chip select still reads
// - page read changes only three low bits
// - timing select moves ready one cycle earlier
package flash_read_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int PAGE_W = 3;
    localparam int WAIT_W = 4;
    localparam logic [WAIT_W-1:0] WAIT_RESET = 4'h3;
    localparam int CLOCK_MHZ = 25;
    localparam int RESET_PULSE_US = 30;
    localparam int RESET_RECOVERY_NS = 200;
    localparam int ASYNC_ACCESS_NS = 80;
    localparam int PAGE_ACCESS_NS = 20;
    localparam int CLOCK_NS = 1000 / CLOCK_MHZ;
    localparam int ASYNC_ACCESS_CYC = (ASYNC_ACCESS_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int PAGE_ACCESS_CYC = (PAGE_ACCESS_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int CNT_W = 5;

    typedef enum logic [1:0] {IDLE, SYNC_WAIT, SYNC_BURST, ASYNC_ACC} mode_e;

    typedef struct packed {
        logic chipSelectN;
        logic outputEnableN;
        logic addressValidStrobeN;
        logic [ADDR_W-1:0] address;
    } bus_in_s;

    typedef struct packed {
        logic [DATA_W-1:0] dataOut;
        logic dataOe;
        logic ready;
        logic readyOe;
    } bus_out_s;
endpackage

// [rtl/pin_sync.sv]
module pin_sync
    import flash_read_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] stable,
    output logic [WIDTH-1:0] agreed
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] val;
    } sync_s;
    sync_s st_q, st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = pinIn;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // change counts only once stages two and three agree
        for (int i = 0; i < WIDTH; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.val[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_q <= '1;
        end else begin
            st_q <= st_d;
        end
    end

    assign stable = st_q.val;
    assign agreed = st_q.s3;
endmodule // pin_sync

// [verif/flash_read_sva.sv]
module flash_read_sva
    import flash_read_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire bus_in_s busIn,
    input wire logic syncMode,
    input wire logic ready_timing_select,
    input wire logic [ADDR_W-1:0] memAddr,
    input wire bus_out_s busOut
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    sequence quiet;
        !syncMode && !busIn.chipSelectN && $stable(busIn.address);
    endsequence
    ready_float_a: assert property (busIn.chipSelectN [*6] |-> !busOut.readyOe)
        else $error("ready not floated");
    data_float_a: assert property (busIn.outputEnableN [*6] |-> !busOut.dataOe)
        else $error("data not floated");
    ready_drive_a: assert property (busOut.ready |-> busOut.readyOe)
        else $error("ready not driven");
    strobe_latch_a: assert property (!syncMode && $rose(busIn.addressValidStrobeN)
        ##1 quiet [*8] |-> memAddr == busIn.address) else $error("strobe latch");
    select_latch_a: assert property (!syncMode && $fell(busIn.chipSelectN)
        ##1 quiet [*8] ##1 quiet [*4] |-> memAddr == busIn.address) else $error("select latch");
    burst_step_a: assert property (syncMode && busOut.ready ##1 busOut.ready
        |-> busOut.dataOut != $past(busOut.dataOut)) else $error("burst stalled");
    early_ready_a: assert property (syncMode && ready_timing_select && $rose(busOut.ready)
        |=> $changed(busOut.dataOut)) else $error("early ready");
    with_data_a: assert property (syncMode && !ready_timing_select && $rose(busOut.ready)
        |-> $changed(busOut.dataOut)) else $error("ready without data");
    cover property (syncMode && $rose(busOut.ready));
    cover property (!syncMode && $rose(busOut.dataOe));
    cover property (ready_timing_select && busOut.ready);
endmodule // flash_read_sva

// [verif/host_model.sv]
module host_model
    import flash_read_pkg::*;
(
    input wire logic clock,
    output bus_in_s busIn
);
    timeunit 1ns;
    timeprecision 1ns;
    initial busIn = '{1'b1, 1'b1, 1'b1, 24'h0};
    // kind 0 strobe pulse, 1 strobe tied to select, 2 strobe before select
    task automatic go(input logic [ADDR_W-1:0] a, input int kind);
        @(posedge clock);
        if (kind == 2) begin
            busIn <= '{1'b1, 1'b1, 1'b0, a};
            repeat (4) @(posedge clock);
            busIn.addressValidStrobeN <= 1'b1;
            @(posedge clock);
            busIn <= '{1'b0, 1'b0, 1'b1, a};
        end else begin
            busIn <= '{1'b0, 1'b0, 1'b0, a};
            if (kind == 0) begin
                repeat (2) @(posedge clock);
                busIn.addressValidStrobeN <= 1'b1;
            end
        end
    endtask
    task automatic mv(input logic [ADDR_W-1:0] a);
        @(posedge clock);
        busIn.address <= a;
    endtask
    // released address shows its inverse, never a stale value
    task automatic stop();
        @(posedge clock);
        busIn <= '{1'b1, 1'b1, 1'b1, ~busIn.address};
    endtask
endmodule // host_model

// [verif/tb.sv]
module tb;
    import flash_read_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic syncMode = 1'b0;
    logic [WAIT_W-1:0] waitStates = 4'h3;
    logic readySel = 1'b0;
    logic [DATA_W-1:0] memData;
    logic [ADDR_W-1:0] memAddr;
    bus_in_s busIn;
    bus_out_s busOut;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    initial forever #20 clock = ~clock;
    host_model host_model_inst (.clock(clock), .busIn(busIn));
    burst_flash_read_port burst_flash_read_port_inst (.clock(clock), .sys_rst(sys_rst),
        .busIn(busIn), .syncMode(syncMode), .wait_state_count(waitStates),
        .ready_timing_select(readySel), .memData(memData), .memAddr(memAddr), .busOut(busOut));
    function automatic logic [DATA_W-1:0] word(input logic [ADDR_W-1:0] a);
        return a[15:0] ^ 16'h5a3c;
    endfunction
    initial memData = 16'h0;
    always @(posedge clock) memData <= word(memAddr);
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            $display("MISMATCH %0t timeout", $time);
            finish_test();
        end
    end
    task automatic t_async(input int k, input logic [ADDR_W-1:0] a);
        syncMode <= 1'b0;
        host_model_inst.go(a, k);
        repeat (10) @(posedge clock);
        #1 chk(busOut.dataOut === word(a) && busOut.dataOe === 1'b1, "async word");
        host_model_inst.stop();
        repeat (8) @(posedge clock);
        #1 chk(busOut.dataOe === 1'b0 && busOut.readyOe === 1'b0, "not floated");
        $display("async test %0d done", k);
    endtask
    task automatic t_page(input logic [ADDR_W-1:0] a);
        syncMode <= 1'b0;
        host_model_inst.go(a, 0);
        for (int i = 0; i < 8; i++) begin
            host_model_inst.mv({a[ADDR_W-1:PAGE_W], PAGE_W'(i)});
            repeat (8) @(posedge clock);
            #1 chk(busOut.dataOut === word({a[ADDR_W-1:PAGE_W], PAGE_W'(i)}), "page");
        end
        host_model_inst.stop();
        repeat (8) @(posedge clock);
        $display("page test done");
    endtask
    task automatic t_sync(input logic sel, input logic [ADDR_W-1:0] a);
        int n = 0;
        syncMode <= 1'b1;
        waitStates <= 4'h3;
        readySel <= sel;
        host_model_inst.go(a, 0);
        while (busOut.ready !== 1'b1 && n < 40) begin
            @(posedge clock);
            #1 n++;
        end
        if (sel === 1'b1) begin
            @(posedge clock);
            #1;
        end
        for (int i = 0; i < 4; i++) begin
            chk(busOut.dataOut === word(a + ADDR_W'(i)) && busOut.ready === 1'b1, "burst");
            @(posedge clock);
            #1;
        end
        host_model_inst.stop();
        repeat (8) @(posedge clock);
        $display("sync test %0d done", sel);
    endtask
    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        // recovery gap before the first read
        repeat (6) @(posedge clock);
        t_async(0, 24'h001234);
        t_async(1, 24'h002345);
        t_async(2, 24'h003456);
        t_page(24'h004560);
        t_sync(1'b0, 24'h005670);
        t_sync(1'b1, 24'h006780);
        finish_test();
    end
endmodule // tb
bind burst_flash_read_port flash_read_sva flash_read_sva_inst (.clock, .sys_rst, .busIn,
    .syncMode, .ready_timing_select, .memAddr, .busOut);
